//--- src/ccd_top.sv
// calibration coefficient decode and correction datapath
// What this block does
// - gain words are unsigned fixed point, 2000 hex is one, bit 14 weighs two.
// - a set top gain bit multiplies the decoded gain by eight.
// - offset words are sixteen-bit two's complement numbers.
// - the signed offset is added to the fourteen-bit converter sample.
// - drift offset and gain are magnitudes signed by bits 11 to 10 of word 01.
// - every square term is a magnitude signed by bits 15 to 12 of word 01.
// - the curve select picks parabolic or S-shaped for bridge, temperature is parabolic.
// - in half offset mode the bridge sample is signed from -8192 to 8191.
// - the temperature sample is unsigned from 0 to 16383.
// - results are delivered in either sleep style or continuous update style.
// - the bridge result gets 2000 hex added, after the square step for S-shaped.
`timescale 1ns/1ps
`default_nettype none
module ccd_top (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cfg_wr_en,
    input wire logic [4:0] cfg_addr,
    input wire logic [15:0] cfg_wr_data,
    output logic [15:0] cfg_rd_data,
    input wire logic update_mode,
    input wire logic measure_req,
    input wire logic conv_valid,
    input wire logic conv_is_temp,
    input wire logic [13:0] raw_sample,
    input wire logic [15:0] gain_coeff,
    input wire logic [15:0] offset_coeff,
    input wire logic [15:0] square_coeff,
    input wire logic [15:0] tco_mag,
    input wire logic [15:0] tcg_mag,
    input wire logic [15:0] tco_square_mag,
    input wire logic [15:0] tcg_square_mag,
    output logic [17:0] gain_value,
    output logic signed [16:0] offset_sum,
    output logic signed [16:0] tco_signed,
    output logic signed [16:0] tcg_signed,
    output logic signed [16:0] tco_square_signed,
    output logic signed [16:0] tcg_square_signed,
    output logic signed [23:0] result,
    output logic result_valid,
    output logic result_is_temp,
    output logic busy
);
    // setup words
    logic [15:0] sign_word_q, sign_word_d;
    logic [15:0] bridge_setup_word_q, bridge_setup_word_d;
    logic [15:0] temp_setup_word_q, temp_setup_word_d;
    logic [15:0] rd_q, rd_d;

    always_comb begin
        sign_word_d = sign_word_q;
        bridge_setup_word_d = bridge_setup_word_q;
        temp_setup_word_d = temp_setup_word_q;
        // trimmed temperature fields are stored as written; keeping them is up to the host
        if (cfg_wr_en) begin
            case (cfg_addr)
                ccd_pkg::ADDR_SIGN: sign_word_d = cfg_wr_data;
                ccd_pkg::ADDR_BRIDGE: bridge_setup_word_d = cfg_wr_data;
                ccd_pkg::ADDR_TEMP: temp_setup_word_d = cfg_wr_data;
                default: sign_word_d = sign_word_q;
            endcase
        end
        case (cfg_addr)
            ccd_pkg::ADDR_SIGN: rd_d = sign_word_q;
            ccd_pkg::ADDR_BRIDGE: rd_d = bridge_setup_word_q;
            ccd_pkg::ADDR_TEMP: rd_d = temp_setup_word_q;
            default: rd_d = ccd_pkg::RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sign_word_q <= ccd_pkg::WORD_RST;
            bridge_setup_word_q <= ccd_pkg::WORD_RST;
            temp_setup_word_q <= ccd_pkg::WORD_RST;
            rd_q <= ccd_pkg::WORD_RST;
        end else begin
            sign_word_q <= sign_word_d;
            bridge_setup_word_q <= bridge_setup_word_d;
            temp_setup_word_q <= temp_setup_word_d;
            rd_q <= rd_d;
        end
    end
    assign cfg_rd_data = rd_q;

    // decode of the captured coefficients
    logic half_mode;
    logic start;
    logic armed_q, armed_d;
    ccd_pkg::ccd_state_e state_q, state_d;
    logic signed [14:0] sample_ext;
    logic [17:0] gain_dec;
    logic sot_neg;

    assign half_mode = bridge_setup_word_q[ccd_pkg::OFFS_SEL_LO +: ccd_pkg::OFFS_SEL_W]
        == ccd_pkg::OFFS_HALF_CODE;
    // sleep style waits for a request; update style takes every sample that arrives while idle
    assign start = (state_q == ccd_pkg::ST_IDLE) && conv_valid && (update_mode || armed_q);

    always_comb begin
        if (conv_is_temp) begin
            sample_ext = $signed({1'b0, raw_sample});
        end else if (half_mode) begin
            sample_ext = $signed({raw_sample[13], raw_sample});
        end else begin
            sample_ext = $signed({1'b0, raw_sample});
        end
        if (gain_coeff[ccd_pkg::GAIN_X8_BIT]) begin
            gain_dec = {gain_coeff[14:0], 3'b000};
        end else begin
            gain_dec = {3'b000, gain_coeff[14:0]};
        end
        sot_neg = conv_is_temp ? sign_word_q[ccd_pkg::SQ_POL_TEMP]
                               : sign_word_q[ccd_pkg::SQ_POL_BRIDGE];
    end

    function automatic logic signed [16:0] apply_sign(input logic neg, input logic [15:0] mag);
        logic signed [16:0] m;
        m = $signed({1'b0, mag});
        apply_sign = neg ? -m : m;
    endfunction

    // arithmetic state
    logic [17:0] gain_d;
    logic signed [16:0] sum_d, sot_q, sot_d;
    logic signed [16:0] tco_d, tcg_d, tco_sq_d, tcg_sq_d;
    logic is_temp_q, is_temp_d, s_curve_q, s_curve_d;
    logic signed [23:0] zb_q, zb_d, sq_q, sq_d, res_d;
    logic res_valid_d, busy_d;
    logic signed [18:0] gain_s;
    logic signed [35:0] prod;
    logic signed [23:0] zb_abs;
    logic signed [47:0] sq_full;
    logic signed [40:0] corr_full;
    logic signed [23:0] corr;

    assign gain_s = $signed({1'b0, gain_value});
    assign prod = gain_s * offset_sum;
    assign zb_abs = zb_q[ccd_pkg::ZW-1] ? -zb_q : zb_q;
    // S-shaped folds in the magnitude so the bend changes sign with the input
    assign sq_full = zb_q * (s_curve_q ? zb_abs : zb_q);
    assign corr_full = sot_q * sq_q;
    assign corr = corr_full[ccd_pkg::SOT_FRAC +: ccd_pkg::ZW];

    always_comb begin
        state_d = state_q;
        armed_d = armed_q;
        gain_d = gain_value;
        sum_d = offset_sum;
        sot_d = sot_q;
        tco_d = tco_signed;
        tcg_d = tcg_signed;
        tco_sq_d = tco_square_signed;
        tcg_sq_d = tcg_square_signed;
        is_temp_d = is_temp_q;
        s_curve_d = s_curve_q;
        zb_d = zb_q;
        sq_d = sq_q;
        res_d = result;
        res_valid_d = 1'b0;
        if (measure_req) begin
            armed_d = 1'b1;
        end
        case (state_q)
            ccd_pkg::ST_IDLE: begin
                if (start) begin
                    armed_d = measure_req;
                    gain_d = gain_dec;
                    sum_d = 17'(sample_ext) + 17'($signed(offset_coeff));
                    sot_d = apply_sign(sot_neg, square_coeff);
                    tco_d = apply_sign(sign_word_q[ccd_pkg::DRIFT_POL_TCO], tco_mag);
                    tcg_d = apply_sign(sign_word_q[ccd_pkg::DRIFT_POL_TCG], tcg_mag);
                    tco_sq_d = apply_sign(sign_word_q[ccd_pkg::SQ_POL_TCO], tco_square_mag);
                    tcg_sq_d = apply_sign(sign_word_q[ccd_pkg::SQ_POL_TCG], tcg_square_mag);
                    is_temp_d = conv_is_temp;
                    s_curve_d = !conv_is_temp && sign_word_q[ccd_pkg::CURVE_BIT];
                    state_d = ccd_pkg::ST_SCALE;
                end
            end
            ccd_pkg::ST_SCALE: begin
                zb_d = prod[ccd_pkg::GAIN_FRAC +: ccd_pkg::ZW];
                // parabolic bridge moves to the unsigned domain before squaring
                if (!is_temp_q && !s_curve_q) begin
                    zb_d = prod[ccd_pkg::GAIN_FRAC +: ccd_pkg::ZW] + ccd_pkg::UNSIGNED_SHIFT;
                end
                state_d = ccd_pkg::ST_SQUARE;
            end
            ccd_pkg::ST_SQUARE: begin
                sq_d = sq_full[ccd_pkg::SQ_SHIFT +: ccd_pkg::ZW];
                state_d = ccd_pkg::ST_APPLY;
            end
            ccd_pkg::ST_APPLY: begin
                res_d = zb_q + corr;
                if (s_curve_q) begin
                    res_d = zb_q + corr + ccd_pkg::UNSIGNED_SHIFT;
                end
                res_valid_d = 1'b1;
                state_d = ccd_pkg::ST_IDLE;
            end
            default: state_d = ccd_pkg::ST_IDLE;
        endcase
        busy_d = state_d != ccd_pkg::ST_IDLE;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= ccd_pkg::ST_IDLE;
            armed_q <= 1'b0;
            gain_value <= '0;
            offset_sum <= '0;
            sot_q <= '0;
            tco_signed <= '0;
            tcg_signed <= '0;
            tco_square_signed <= '0;
            tcg_square_signed <= '0;
            is_temp_q <= 1'b0;
            s_curve_q <= 1'b0;
            zb_q <= '0;
            sq_q <= '0;
            result <= '0;
            result_valid <= 1'b0;
            busy <= 1'b0;
        end else begin
            state_q <= state_d;
            armed_q <= armed_d;
            gain_value <= gain_d;
            offset_sum <= sum_d;
            sot_q <= sot_d;
            tco_signed <= tco_d;
            tcg_signed <= tcg_d;
            tco_square_signed <= tco_sq_d;
            tcg_square_signed <= tcg_sq_d;
            is_temp_q <= is_temp_d;
            s_curve_q <= s_curve_d;
            zb_q <= zb_d;
            sq_q <= sq_d;
            result <= res_d;
            result_valid <= res_valid_d;
            busy <= busy_d;
        end
    end
    assign result_is_temp = is_temp_q;

    // checks
    AST_GAIN_UNITY: assert property (@(posedge clk_sys) disable iff (!nrst)
        start && gain_coeff == ccd_pkg::GAIN_UNITY |=> gain_value == 18'h02000)
        else $error("unity gain not decoded as one");
    AST_GAIN_X8: assert property (@(posedge clk_sys) disable iff (!nrst)
        start && gain_coeff[ccd_pkg::GAIN_X8_BIT] |=> gain_value[2:0] == 3'h0
            && gain_value[17:3] == $past(gain_coeff[14:0]))
        else $error("times eight gain not applied");
    AST_OFFSET_NEG: assert property (@(posedge clk_sys) disable iff (!nrst)
        start && conv_is_temp && offset_coeff == 16'hfffc
            |=> offset_sum == $signed({3'b000, $past(raw_sample)}) - 17'sd4)
        else $error("negative offset not added to temperature sample");
    AST_BRIDGE_SIGNED: assert property (@(posedge clk_sys) disable iff (!nrst)
        start && !conv_is_temp && half_mode && raw_sample[13] && offset_coeff == 16'h0000
            |=> offset_sum < 0)
        else $error("half mode bridge sample not signed");
    AST_DRIFT_SIGN: assert property (@(posedge clk_sys) disable iff (!nrst)
        start && sign_word_q[ccd_pkg::DRIFT_POL_TCG]
            |=> tcg_signed == -$signed({1'b0, $past(tcg_mag)}))
        else $error("drift gain polarity not applied");
    AST_DRIFT_POS: assert property (@(posedge clk_sys) disable iff (!nrst)
        start && !sign_word_q[ccd_pkg::DRIFT_POL_TCO]
            |=> tco_signed == $signed({1'b0, $past(tco_mag)}))
        else $error("positive drift offset altered");
    AST_SQ_SIGN: assert property (@(posedge clk_sys) disable iff (!nrst)
        start && !conv_is_temp && sign_word_q[ccd_pkg::SQ_POL_BRIDGE] && square_coeff != 16'h0000
            |=> sot_q < 0)
        else $error("bridge square term polarity not applied");
    AST_LATENCY: assert property (@(posedge clk_sys) disable iff (!nrst)
        start |=> !result_valid [*3] ##1 result_valid)
        else $error("result not delivered four cycles after start");
    AST_TEMP_PLAIN: assert property (@(posedge clk_sys) disable iff (!nrst)
        start && conv_is_temp && gain_coeff == ccd_pkg::GAIN_UNITY && offset_coeff == 16'h0000
            && square_coeff == 16'h0000 |-> ##4 result == $signed({10'h000, $past(raw_sample, 4)}))
        else $error("temperature result shifted or bent");
    AST_BRIDGE_SHIFT: assert property (@(posedge clk_sys) disable iff (!nrst)
        start && !conv_is_temp && !half_mode && gain_coeff == ccd_pkg::GAIN_UNITY
            && offset_coeff == 16'h0000 && square_coeff == 16'h0000
            |-> ##4 result == $signed({10'h000, $past(raw_sample, 4)}) + ccd_pkg::UNSIGNED_SHIFT)
        else $error("bridge result not moved to unsigned domain");
    AST_SLEEP_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
        state_q == ccd_pkg::ST_IDLE && conv_valid && !update_mode && !armed_q |=> !busy)
        else $error("sleep style started without request");
    // a pending request must not be lost once a sample arrives
    AST_SLEEP_TAKE: assert property (@(posedge clk_sys) disable iff (!nrst)
        state_q == ccd_pkg::ST_IDLE && conv_valid && !update_mode && armed_q |=> busy)
        else $error("armed sleep style request not taken");
    // half offset mode must never leak into the temperature channel
    AST_TEMP_UNSIGNED: assert property (@(posedge clk_sys) disable iff (!nrst)
        start && conv_is_temp && offset_coeff == 16'h0000
            |=> offset_sum == $signed({3'b000, $past(raw_sample)}))
        else $error("temperature sample not taken as unsigned");
    AST_TEMP_PARABOLIC: assert property (@(posedge clk_sys) disable iff (!nrst)
        start && conv_is_temp |=> !s_curve_q)
        else $error("temperature correction not parabolic");
endmodule
`default_nettype wire

//--- src/ccd_pkg.sv
// constants and types shared by the calibration coefficient datapath
package ccd_pkg;
    localparam int CW = 16;
    localparam int SW = 14;
    localparam int ZW = 24;
    // setup word addresses
    localparam logic [4:0] ADDR_SIGN = 5'h01;
    localparam logic [4:0] ADDR_BRIDGE = 5'h0f;
    localparam logic [4:0] ADDR_TEMP = 5'h10;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] RD_UNMAPPED = 16'h0000;
    // field positions inside the setup words and the gain coefficient
    localparam int GAIN_X8_BIT = 15;
    localparam int CURVE_BIT = 9;
    localparam int DRIFT_POL_TCO = 10;
    localparam int DRIFT_POL_TCG = 11;
    localparam int SQ_POL_BRIDGE = 12;
    localparam int SQ_POL_TEMP = 13;
    localparam int SQ_POL_TCO = 14;
    localparam int SQ_POL_TCG = 15;
    localparam int OFFS_SEL_LO = 0;
    localparam int OFFS_SEL_W = 4;
    localparam logic [3:0] OFFS_HALF_CODE = 4'h8;
    // fixed point scaling
    localparam int GAIN_FRAC = 13;
    localparam int SQ_SHIFT = 13;
    localparam int SOT_FRAC = 15;
    localparam logic [15:0] GAIN_UNITY = 16'h2000;
    localparam logic signed [23:0] UNSIGNED_SHIFT = 24'sh002000;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SCALE,
        ST_SQUARE,
        ST_APPLY
    } ccd_state_e;
endpackage

//--- sim/ccd_top_tb.sv
// self-checking testbench for the calibration coefficient datapath
`timescale 1ns/1ps
`default_nettype none
module ccd_top_tb;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic cfg_wr_en = 1'b0;
    logic [4:0] cfg_addr = 5'h00;
    logic [15:0] cfg_wr_data = 16'h0000;
    logic [15:0] cfg_rd_data;
    logic update_mode = 1'b1;
    logic measure_req = 1'b0;
    logic conv_valid = 1'b0;
    logic conv_is_temp = 1'b0;
    logic [13:0] raw_sample = 14'h0000;
    logic [15:0] gain_coeff = 16'h0000;
    logic [15:0] offset_coeff = 16'h0000;
    logic [15:0] square_coeff = 16'h0000;
    logic [15:0] tco_mag = 16'h0000;
    logic [15:0] tcg_mag = 16'h0000;
    logic [15:0] tco_square_mag = 16'h0000;
    logic [15:0] tcg_square_mag = 16'h0000;
    logic [17:0] gain_value;
    logic signed [16:0] offset_sum, tco_signed, tcg_signed;
    logic signed [16:0] tco_square_signed, tcg_square_signed;
    logic signed [23:0] result;
    logic result_valid, result_is_temp, busy;
    int errors = 0;
    int cmp_count = 0;
    logic [15:0] rdv;

    ccd_top ccd_top_inst (.clk_sys(clk_sys), .nrst(nrst), .cfg_wr_en(cfg_wr_en),
        .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
        .update_mode(update_mode), .measure_req(measure_req), .conv_valid(conv_valid),
        .conv_is_temp(conv_is_temp), .raw_sample(raw_sample), .gain_coeff(gain_coeff),
        .offset_coeff(offset_coeff), .square_coeff(square_coeff), .tco_mag(tco_mag),
        .tcg_mag(tcg_mag), .tco_square_mag(tco_square_mag),
        .tcg_square_mag(tcg_square_mag), .gain_value(gain_value),
        .offset_sum(offset_sum), .tco_signed(tco_signed), .tcg_signed(tcg_signed),
        .tco_square_signed(tco_square_signed), .tcg_square_signed(tcg_square_signed),
        .result(result), .result_valid(result_valid), .result_is_temp(result_is_temp),
        .busy(busy));

    always #2.5 clk_sys = ~clk_sys;

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        cfg_wr_en = 1'b1;
        cfg_addr = a;
        cfg_wr_data = d;
        step;
        cfg_wr_en = 1'b0;
        step;
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        cfg_addr = a;
        step;
        d = cfg_rd_data;
    endtask

    // one take, then a bounded wait for the result pulse
    task automatic run(input logic tmp, input logic [13:0] raw, input logic [15:0] g,
                       input logic [15:0] o, input logic [15:0] s);
        int lat;
        conv_is_temp = tmp;
        raw_sample = raw;
        gain_coeff = g;
        offset_coeff = o;
        square_coeff = s;
        conv_valid = 1'b1;
        step;
        conv_valid = 1'b0;
        chk({31'h0, busy}, 32'h1);
        lat = 1;
        while (result_valid !== 1'b1 && lat < 12) begin
            step;
            lat++;
        end
        chk(lat, 4);
        chk({30'h0, busy, result_is_temp}, {31'h0, tmp});
    endtask

    task automatic t_reset;
        repeat (3) step;
        chk({result, gain_value}, 42'h0);
        chk({offset_sum, cfg_rd_data, busy, result_valid}, 35'h0);
        nrst = 1'b1;
        rd(5'h01, rdv);
        chk(rdv, 16'h0000);
    endtask

    task automatic t_regs;
        wr(5'h01, 16'ha5c3);
        wr(5'h0f, 16'h1234);
        wr(5'h10, 16'h1490);
        wr(5'h05, 16'hffff);
        rd(5'h01, rdv);
        chk(rdv, 16'ha5c3);
        rd(5'h0f, rdv);
        chk(rdv, 16'h1234);
        rd(5'h10, rdv);
        chk(rdv, 16'h1490);
        rd(5'h05, rdv);
        chk(rdv, 16'h0000);
    endtask

    task automatic t_decode;
        tco_mag = 16'h0005;
        tcg_mag = 16'h0007;
        tco_square_mag = 16'h0003;
        tcg_square_mag = 16'h0009;
        wr(5'h0f, 16'h0000);
        wr(5'h01, 16'h4400);
        run(1'b1, 14'h3fff, 16'h4a62, 16'hfffc, 16'h0000);
        chk(gain_value, 18'h04a62);
        chk(offset_sum, 17'h03ffb);
        chk({tco_signed, tcg_signed}, {17'h1fffb, 17'h00007});
        chk({tco_square_signed, tcg_square_signed}, {17'h1fffd, 17'h00009});
        wr(5'h01, 16'h8800);
        run(1'b0, 14'h3fff, 16'hd896, 16'h0000, 16'h0000);
        chk(gain_value, 18'h2c4b0);
        chk(offset_sum, 17'h03fff);
        chk({tco_signed, tcg_signed}, {17'h00005, 17'h1fff9});
        chk({tco_square_signed, tcg_square_signed}, {17'h00003, 17'h1fff7});
        wr(5'h0f, 16'h0008);
        run(1'b0, 14'h3fff, 16'h2000, 16'h0001, 16'h0000);
        chk(offset_sum, 17'h00000);
        run(1'b0, 14'h2000, 16'h2000, 16'h0000, 16'h0000);
        chk({offset_sum}, 17'h1e000);
        run(1'b1, 14'h3fff, 16'h2000, 16'h0000, 16'h0000);
        chk({offset_sum}, 17'h03fff);
    endtask

    task automatic t_result;
        wr(5'h0f, 16'h0000);
        wr(5'h01, 16'h0000);
        run(1'b0, 14'h0000, 16'h2000, 16'h0100, 16'h4000);
        chk({8'h0, result}, 32'h003204);
        run(1'b0, 14'h0123, 16'h2000, 16'h0000, 16'h0000);
        chk({8'h0, result}, 32'h002123);
        wr(5'h01, 16'h0200);
        run(1'b0, 14'h0000, 16'h2000, 16'h0100, 16'h4000);
        chk({8'h0, result}, 32'h002104);
        // negative zb shows temperature stays parabolic with the curve bit set
        run(1'b1, 14'h0000, 16'h2000, 16'hf000, 16'h4000);
        chk({8'h0, result}, 32'hfff400);
        wr(5'h01, 16'h2000);
        run(1'b1, 14'h1000, 16'h2000, 16'h0000, 16'h0200);
        chk({8'h0, result}, 32'h000fe0);
        wr(5'h01, 16'h1000);
        run(1'b0, 14'h0000, 16'h2000, 16'h0000, 16'h0200);
        chk({8'h0, result}, 32'h001f80);
    endtask

    task automatic t_flow;
        int seen;
        seen = 0;
        update_mode = 1'b0;
        conv_valid = 1'b1;
        step;
        conv_valid = 1'b0;
        repeat (6) begin
            step;
            seen = seen | result_valid;
        end
        chk(seen, 0);
        measure_req = 1'b1;
        step;
        measure_req = 1'b0;
        run(1'b0, 14'h0000, 16'h2000, 16'h0010, 16'h0000);
        chk(offset_sum, 17'h00010);
        update_mode = 1'b1;
        step;
        run(1'b0, 14'h0000, 16'h2000, 16'h0020, 16'h0000);
        step;
        chk({31'h0, result_valid}, 32'h0);
        offset_coeff = 16'h0030;
        conv_valid = 1'b1;
        step;
        offset_coeff = 16'h0040;
        step;
        conv_valid = 1'b0;
        repeat (2) step;
        chk({31'h0, result_valid}, 32'h1);
        chk(offset_sum, 17'h00030);
    endtask

    initial begin
        t_reset;
        t_regs;
        t_decode;
        t_result;
        t_flow;
        complete_run;
    end

    // the whole sequence needs well under 400 cycles
    initial begin
        #20000;
        errors++;
        complete_run;
    end
endmodule
`default_nettype wire
